/* File: ltcr_pkg.sv */
// Shared constants for the line transceiver control register bank.
`default_nettype none
package ltcr_pkg;
  // ==========================================================
  // Register indices; byte address is four times the index.
  localparam int unsigned IDX_SHORT_FAULT_IRQ_MASK   = 32'h07;
  localparam int unsigned IDX_INPUT_ABSENT_IRQ_FLAGS = 32'h08;
  localparam int unsigned IDX_SHORT_FAULT_IRQ_FLAGS  = 32'h09;
  localparam int unsigned IDX_SOFT_CLEAR_TRIGGER     = 32'h0a;
  localparam int unsigned IDX_SPARE_ZERO_BYTE        = 32'h0b;
  localparam int unsigned IDX_NEAR_END_LOOPBACK_CTRL = 32'h0c;
  localparam int unsigned IDX_ABSENT_CRITERIA_SELECT = 32'h0d;
  localparam int unsigned IDX_AUTO_MARKS_ON_ABSENT   = 32'h0e;
  localparam int unsigned ADDR_LSB                   = 2;
  // ==========================================================
  // Widths and reset values.
  localparam int unsigned NUM_RX    = 4;
  localparam int unsigned NUM_TX    = 2;
  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ==========================================================
  // Timing.
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned SOFT_CLEAR_NS   = 1;
  localparam int unsigned SOFT_CLEAR_CYC  = (SOFT_CLEAR_NS * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CLR_CNT_W       = 8;
endpackage
`default_nettype wire

/* File: ltcr_regs.sv */
// AXI4-Lite control and status register bank of a dual line transceiver.
`default_nettype none
// How it works
// - Mask bit one enables its driver-fault interrupt.
// - Mask register is zero after reset.
// - Receiver absent-status change sets its flag.
// - Transceiver fault-status change sets its flag.
// - Any soft clear write outside a running clear starts 1 us clear.
// - Soft clear restores every register default.
// - Loopback bit one enables channel digital loopback.
// - T1 mode ignores criteria bits entirely.
// - E1 with bit one uses alternate criteria.
// - E1 with bit zero uses default criteria.
// - Alarm detection fully compliant only bit zero.
// - Auto bit sends all ones on absence.
// - No auto all ones when both clocks high.
// - All ones means continuous marks on output.
// - One read clears all pending absent flags.
// - Short monitor detection registers a fault.
module ltcr_regs
  import ltcr_pkg::*;
#(
  parameter int unsigned ADDR_W = 6
)
(
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [ADDR_W-1:0]              s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output var  logic                           s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output var  logic                           s_axi_wready,
  output var  logic [1:0]                     s_axi_bresp,
  output var  logic                           s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [ADDR_W-1:0]              s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output var  logic                           s_axi_arready,
  output var  logic [31:0]                    s_axi_rdata,
  output var  logic [1:0]                     s_axi_rresp,
  output var  logic                           s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic [ltcr_pkg::NUM_RX-1:0]    input_absent_condition,
  input  wire logic [ltcr_pkg::NUM_TX-1:0]    driver_fault_monitor,
  input  wire logic [ltcr_pkg::NUM_RX-1:0]    input_absent_irq_enable,
  input  wire logic                           e1_mode,
  input  wire logic                           ref_clock_held_high,
  input  wire logic                           tx_line_clock_held_high,
  output var  logic [ltcr_pkg::NUM_RX-1:0]    near_end_loopback_en,
  output var  logic [ltcr_pkg::NUM_RX-1:0]    alt_absent_criteria_en,
  output var  logic [ltcr_pkg::NUM_TX-1:0]    all_ones_transmit,
  output var  logic                           soft_clear_busy,
  output var  logic                           irq
);
  import ltcr_pkg::*;

  initial
  begin
    if (ADDR_W < 6 || ADDR_W > 32)
    begin
      $error("ADDR_W must lie between 6 and 32.");
    end
    if (SOFT_CLEAR_CYC < 1 || SOFT_CLEAR_CYC >= (1 << CLR_CNT_W))
    begin
      $error("SOFT_CLEAR_CYC must fit the clear counter.");
    end
  end

  // ==========================================================
  // Register state.
  logic [NUM_TX-1:0]      short_fault_irq_mask_reg;
  logic [NUM_RX-1:0]      input_absent_irq_flags_reg;
  logic [NUM_TX-1:0]      short_fault_irq_flags_reg;
  logic [NUM_RX-1:0]      near_end_loopback_ctrl_reg;
  logic [NUM_RX-1:0]      absent_criteria_select_reg;
  logic [NUM_TX-1:0]      auto_marks_on_absent_reg;
  logic [NUM_RX-1:0]      absent_prev_reg;
  logic [NUM_TX-1:0]      fault_prev_reg;
  logic [CLR_CNT_W-1:0]   clear_cnt_reg;
  logic                   aw_have_reg;
  logic                   w_have_reg;
  logic                   w_lane0_reg;
  logic [ADDR_W-1:0]      aw_addr_reg;
  logic [31:0]            w_data_reg;
  logic                   do_write;
  logic                   do_read;
  logic [ADDR_W-3:0]      w_idx;
  logic [ADDR_W-3:0]      r_idx;
  logic                   wr_clear;
  logic                   clearing;
  logic                   rd_absent_flags;
  logic                   rd_fault_flags;
  logic [NUM_RX-1:0]      absent_change;
  logic [NUM_TX-1:0]      fault_change;

  assign clearing = (clear_cnt_reg != '0);
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign do_read  = s_axi_arvalid && s_axi_arready;
  assign w_idx    = aw_addr_reg[ADDR_W-1:ADDR_LSB];
  assign r_idx    = s_axi_araddr[ADDR_W-1:ADDR_LSB];
  // Writes landing during the 200-cycle clear are answered but dropped, so software cannot race the clear.
  assign wr_clear = do_write && !clearing && (w_idx == (ADDR_W-2)'(IDX_SOFT_CLEAR_TRIGGER));
  assign rd_absent_flags = do_read && (r_idx == (ADDR_W-2)'(IDX_INPUT_ABSENT_IRQ_FLAGS));
  assign rd_fault_flags  = do_read && (r_idx == (ADDR_W-2)'(IDX_SHORT_FAULT_IRQ_FLAGS));
  assign absent_change   = input_absent_condition ^ absent_prev_reg;
  assign fault_change    = driver_fault_monitor ^ fault_prev_reg;

  function automatic logic wr_hit(input logic [ADDR_W-3:0] idx, input int unsigned target);
    wr_hit = do_write && !clearing && (idx == (ADDR_W-2)'(target)) && w_lane0_reg;
  endfunction

  // ==========================================================
  // Soft clear timer.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clear_cnt_reg <= '0;
    end
    else if (wr_clear)
    begin
      clear_cnt_reg <= CLR_CNT_W'(SOFT_CLEAR_CYC);
    end
    else if (clearing)
    begin
      clear_cnt_reg <= clear_cnt_reg - 1'b1;
    end
  end

  // ==========================================================
  // Control registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clearing)
    begin
      short_fault_irq_mask_reg   <= REG_RESET[NUM_TX-1:0];
      near_end_loopback_ctrl_reg <= REG_RESET[NUM_RX-1:0];
      absent_criteria_select_reg <= REG_RESET[NUM_RX-1:0];
      auto_marks_on_absent_reg   <= REG_RESET[NUM_TX-1:0];
    end
    else
    begin
      if (wr_hit(w_idx, IDX_SHORT_FAULT_IRQ_MASK))
      begin
        short_fault_irq_mask_reg <= w_data_reg[NUM_TX-1:0];
      end
      if (wr_hit(w_idx, IDX_NEAR_END_LOOPBACK_CTRL))
      begin
        near_end_loopback_ctrl_reg <= w_data_reg[NUM_RX-1:0];
      end
      if (wr_hit(w_idx, IDX_ABSENT_CRITERIA_SELECT))
      begin
        absent_criteria_select_reg <= w_data_reg[NUM_RX-1:0];
      end
      if (wr_hit(w_idx, IDX_AUTO_MARKS_ON_ABSENT))
      begin
        auto_marks_on_absent_reg <= w_data_reg[NUM_TX-1:0];
      end
    end
  end

  // ==========================================================
  // Change flags; a new change in the clearing read cycle wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clearing)
    begin
      absent_prev_reg            <= input_absent_condition;
      fault_prev_reg             <= driver_fault_monitor;
      input_absent_irq_flags_reg <= REG_RESET[NUM_RX-1:0];
      short_fault_irq_flags_reg  <= REG_RESET[NUM_TX-1:0];
    end
    else
    begin
      absent_prev_reg <= input_absent_condition;
      fault_prev_reg  <= driver_fault_monitor;
      input_absent_irq_flags_reg <= (rd_absent_flags ? '0 : input_absent_irq_flags_reg) | absent_change;
      short_fault_irq_flags_reg  <= (rd_fault_flags ? '0 : short_fault_irq_flags_reg) | fault_change;
    end
  end

  // ==========================================================
  // Line-side controls, registered.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RX; gi++)
    begin : g_rx
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          near_end_loopback_en[gi]   <= 1'b0;
          alt_absent_criteria_en[gi] <= 1'b0;
        end
        else
        begin
          near_end_loopback_en[gi]   <= near_end_loopback_ctrl_reg[gi];
          // Low selects the default criteria, the only choice with fully compliant alarm detection.
          alt_absent_criteria_en[gi] <= e1_mode && absent_criteria_select_reg[gi];
        end
      end
    end
    for (gi = 0; gi < NUM_TX; gi++)
    begin : g_tx
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          all_ones_transmit[gi] <= 1'b0;
        end
        else
        begin
          all_ones_transmit[gi] <= auto_marks_on_absent_reg[gi] && input_absent_condition[gi]
                                   && !(ref_clock_held_high && tx_line_clock_held_high);
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq             <= 1'b0;
      soft_clear_busy <= 1'b0;
    end
    else
    begin
      irq <= |(input_absent_irq_flags_reg & input_absent_irq_enable)
             || |(short_fault_irq_flags_reg & short_fault_irq_mask_reg);
      soft_clear_busy <= wr_clear || (clear_cnt_reg > CLR_CNT_W'(1));
    end
  end

  // ==========================================================
  // AXI4-Lite write channel.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_lane0_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        // The strobe is kept with the data, since the master may change it once W is taken.
        w_lane0_reg  <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (w_idx >= (ADDR_W-2)'(IDX_SHORT_FAULT_IRQ_MASK)
                         && w_idx <= (ADDR_W-2)'(IDX_AUTO_MARKS_ON_ABSENT)) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
      case (r_idx)
        (ADDR_W-2)'(IDX_SHORT_FAULT_IRQ_MASK):   s_axi_rdata[NUM_TX-1:0] <= short_fault_irq_mask_reg;
        (ADDR_W-2)'(IDX_INPUT_ABSENT_IRQ_FLAGS): s_axi_rdata[NUM_RX-1:0] <= input_absent_irq_flags_reg;
        (ADDR_W-2)'(IDX_SHORT_FAULT_IRQ_FLAGS):  s_axi_rdata[NUM_TX-1:0] <= short_fault_irq_flags_reg;
        (ADDR_W-2)'(IDX_SOFT_CLEAR_TRIGGER):     s_axi_rdata <= '0;
        (ADDR_W-2)'(IDX_SPARE_ZERO_BYTE):        s_axi_rdata <= '0;
        (ADDR_W-2)'(IDX_NEAR_END_LOOPBACK_CTRL): s_axi_rdata[NUM_RX-1:0] <= near_end_loopback_ctrl_reg;
        (ADDR_W-2)'(IDX_ABSENT_CRITERIA_SELECT): s_axi_rdata[NUM_RX-1:0] <= absent_criteria_select_reg;
        (ADDR_W-2)'(IDX_AUTO_MARKS_ON_ABSENT):   s_axi_rdata[NUM_TX-1:0] <= auto_marks_on_absent_reg;
        default:                                 s_axi_rresp <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: ltcr_regs_assertions.sv */
// Port-level checker of the control register bank.
`default_nettype none
module ltcr_assertions
(
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire logic [ltcr_pkg::NUM_RX-1:0] input_absent_condition,
  input wire logic                        e1_mode,
  input wire logic                        ref_clock_held_high,
  input wire logic                        tx_line_clock_held_high,
  input wire logic [ltcr_pkg::NUM_RX-1:0] near_end_loopback_en,
  input wire logic [ltcr_pkg::NUM_RX-1:0] alt_absent_criteria_en,
  input wire logic [ltcr_pkg::NUM_TX-1:0] all_ones_transmit,
  input wire logic                        soft_clear_busy,
  input wire logic                        irq
);
  import ltcr_pkg::*;
  // ====================
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property (
    $rose(aresetn) |-> irq == 1'b0 && near_end_loopback_en == 4'h0) else $error("outputs not quiet after reset");
  a_clear_span: assert property (
    $rose(soft_clear_busy) |-> ##199 soft_clear_busy ##1 !soft_clear_busy) else $error("soft clear length wrong");
  // The line outputs lag the held registers by one cycle, so the check starts on the third busy cycle.
  a_clear_holds: assert property (
    soft_clear_busy && $past(soft_clear_busy) && $past(soft_clear_busy, 2)
    |-> near_end_loopback_en == 4'h0 && irq == 1'b0)
    else $error("state not held clear");
  a_t1_ignores: assert property (
    !e1_mode |=> alt_absent_criteria_en == 4'h0) else $error("criteria used in T1");
  a_e1_only: assert property (
    alt_absent_criteria_en != 4'h0 |-> $past(e1_mode)) else $error("criteria without E1");
  a_marks_cause: assert property (
    (all_ones_transmit & ~$past(input_absent_condition[1:0])) == 2'h0) else $error("marks without absence");
  a_marks_blocked: assert property (
    ref_clock_held_high && tx_line_clock_held_high |=> all_ones_transmit == 2'h0) else $error("marks in recovery");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
endmodule
bind ltcr_regs ltcr_assertions u_chk (.*);
`default_nettype wire

/* File: ltcr_host.sv */
// Host model that reaches the register bank over AXI4-Lite.
`default_nettype none
module ltcr_host
(
  input  wire logic        aclk,
  output var  logic [5:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [5:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  import ltcr_pkg::*;
  // ====================
  // Bus cycles
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Address and data leave together; each is dropped only at its own acceptance.
  task automatic wr(input int unsigned idx, input logic [7:0] val, output logic [1:0] resp,
                    input logic [3:0] lanes = 4'h1);
    @(posedge aclk);
    s_axi_awaddr <= 6'(idx << ADDR_LSB);
    s_axi_wdata <= {24'h000000, val};
    s_axi_wstrb <= lanes;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input int unsigned idx, output logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= 6'(idx << ADDR_LSB);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the control register bank.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ltcr_pkg::*;
  // ====================
  // Signals and instances
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb, input_absent_condition, input_absent_irq_enable, near_end_loopback_en, alt_absent_criteria_en;
  logic [1:0]  s_axi_bresp, s_axi_rresp, driver_fault_monitor, all_ones_transmit, rd_r;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, e1_mode, ref_clock_held_high;
  logic        tx_line_clock_held_high, soft_clear_busy, irq;
  int          err_total, num_checks, cycles;
  ltcr_regs dut (.*);
  ltcr_host host (.*);
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // The ceiling is far above the few hundred cycles the scenarios need.
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  // ====================
  // Checking
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ====================
  // Scenarios
  task automatic t_reset();
    for (int i = IDX_SHORT_FAULT_IRQ_MASK; i <= IDX_AUTO_MARKS_ON_ABSENT; i++)
    begin
      host.rd(i, rd_d, rd_r);
      chk(rd_d, 32'h0);
    end
    host.rd(32'h0f, rd_d, rd_r);
    chk(32'(rd_r), 32'(RESP_SLVERR));
    host.wr(32'h0f, 8'h00, rd_r);
    chk(32'(rd_r), 32'(RESP_SLVERR));
  endtask
  task automatic t_ctrl();
    host.wr(IDX_NEAR_END_LOOPBACK_CTRL, 8'h0a, rd_r);
    host.wr(IDX_ABSENT_CRITERIA_SELECT, 8'h05, rd_r);
    host.wr(IDX_SHORT_FAULT_IRQ_MASK, 8'h03, rd_r);
    chk(32'(rd_r), 32'(RESP_OKAY));
    host.wr(IDX_AUTO_MARKS_ON_ABSENT, 8'h03, rd_r, 4'h0);
    host.rd(IDX_AUTO_MARKS_ON_ABSENT, rd_d, rd_r);
    chk(rd_d, 32'h0);
    host.rd(IDX_SHORT_FAULT_IRQ_MASK, rd_d, rd_r);
    chk(rd_d, 32'h03);
    chk(near_end_loopback_en, 4'ha);
    chk(alt_absent_criteria_en, 4'h5);
    e1_mode <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(alt_absent_criteria_en, 4'h0);
    e1_mode <= 1'b1;
  endtask
  task automatic t_marks();
    host.wr(IDX_AUTO_MARKS_ON_ABSENT, 8'h01, rd_r);
    input_absent_condition <= 4'h1;
    repeat (3) @(posedge aclk);
    chk(all_ones_transmit, 2'h1);
    {ref_clock_held_high, tx_line_clock_held_high} <= 2'h3;
    repeat (3) @(posedge aclk);
    chk(all_ones_transmit, 2'h0);
    {ref_clock_held_high, tx_line_clock_held_high, input_absent_condition} <= 6'h00;
    repeat (3) @(posedge aclk);
  endtask
  // Flags from earlier scenarios are read away first so each case starts clean.
  task automatic t_flags();
    host.rd(IDX_INPUT_ABSENT_IRQ_FLAGS, rd_d, rd_r);
    {input_absent_irq_enable, input_absent_condition} <= 8'h44;
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    host.rd(IDX_INPUT_ABSENT_IRQ_FLAGS, rd_d, rd_r);
    chk(rd_d, 32'h04);
    host.rd(IDX_INPUT_ABSENT_IRQ_FLAGS, rd_d, rd_r);
    chk(rd_d, 32'h00);
    chk(irq, 1'b0);
    {input_absent_irq_enable, driver_fault_monitor} <= 6'h02;
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    host.rd(IDX_SHORT_FAULT_IRQ_FLAGS, rd_d, rd_r);
    chk(rd_d, 32'h02);
    host.wr(IDX_SHORT_FAULT_IRQ_MASK, 8'h00, rd_r);
    driver_fault_monitor <= 2'h0;
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    host.rd(IDX_SHORT_FAULT_IRQ_FLAGS, rd_d, rd_r);
    chk(rd_d, 32'h02);
  endtask
  task automatic t_clear();
    host.wr(IDX_SOFT_CLEAR_TRIGGER, 8'h00, rd_r);
    chk(soft_clear_busy, 1'b1);
    host.wr(IDX_NEAR_END_LOOPBACK_CTRL, 8'h0f, rd_r);
    repeat (400) @(posedge aclk);
    chk(soft_clear_busy, 1'b0);
    chk(near_end_loopback_en, 4'h0);
    for (int i = IDX_SHORT_FAULT_IRQ_MASK; i <= IDX_AUTO_MARKS_ON_ABSENT; i++)
    begin
      host.rd(i, rd_d, rd_r);
      chk(rd_d, 32'h0);
    end
  endtask
  initial
  begin
    {aresetn, ref_clock_held_high, tx_line_clock_held_high} = 3'h0;
    {input_absent_condition, input_absent_irq_enable, driver_fault_monitor} = 10'h000;
    e1_mode = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_marks();
    t_flags();
    t_clear();
    wrap_up();
  end
endmodule
`default_nettype wire
